// ---- core/rcp_pkg.sv ----
// package: constants, register map and carrier types for the clear/preset control block
package rcp_pkg;

    // ********************************************************************
    // sizes
    // ********************************************************************
    localparam int unsigned CELLS   = 8;  // cell_unit registers per cluster
    localparam int unsigned CLUSTER = 4;  // logic_cluster count
    localparam int unsigned NREG    = CELLS * CLUSTER;

    // ********************************************************************
    // register map (byte offsets)
    // ********************************************************************
    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_DATA    = 12'h004;
    localparam logic [11:0] OFS_Q       = 12'h008;
    localparam logic [11:0] OFS_INITV   = 12'h00C;
    localparam logic [11:0] OFS_CLRA    = 12'h010;
    localparam logic [11:0] OFS_CLRB    = 12'h014;
    localparam logic [11:0] OFS_PRE     = 12'h018;
    localparam logic [11:0] OFS_CLRSEL  = 12'h01C;
    localparam logic [11:0] OFS_STATUS  = 12'h020;

    // ctrl fields
    localparam int unsigned CTRL_RST_EN = 0;  // chip-wide reset function on
    localparam int unsigned CTRL_GPIO_O = 1;  // pin drive value in gpio mode
    localparam int unsigned CTRL_GPIO_D = 2;  // pin drive enable in gpio mode
    localparam int unsigned CTRL_LOAD   = 3;  // write 1: capture data input

    // status fields
    localparam int unsigned STA_PIN     = 0;
    localparam int unsigned STA_CHIPRST = 1;

    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

    // ********************************************************************
    // carrier types
    // ********************************************************************
    typedef struct packed {
        logic [1:0] clr;  // two independent clears per cluster
        logic       pre;  // one preset per cluster
    } rcp_ctl_s;

    typedef struct packed {
        logic [CELLS-1:0] d;
        logic [CELLS-1:0] init;
        logic [CELLS-1:0] csel;
        logic             load;
    } rcp_cell_in_s;

    typedef enum logic [1:0] {
        RCP_IDLE   = 2'b00,
        RCP_ACCESS = 2'b01
    } rcp_phase_e;

endpackage

// ---- core/rcp_cluster.sv ----
// one logic cluster: cell_unit registers sharing clear and preset lines
`timescale 1ns/10ps
`default_nettype none
module rcp_cluster (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          chip_reset,
    input  wire logic                          init_req,
    input  wire rcp_pkg::rcp_ctl_s             ctl,
    input  wire rcp_pkg::rcp_cell_in_s         cin,
    output logic [rcp_pkg::CELLS-1:0]          q
);

    // ********************************************************************
    // cell registers
    // ********************************************************************
    genvar i;
    generate
        for (i = 0; i < rcp_pkg::CELLS; i++) begin : g_cell
            wire logic clr_i;
            assign clr_i = cin.csel[i] ? ctl.clr[1] : ctl.clr[0];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    q[i] <= 1'b0;
                end else if (chip_reset) begin
                    q[i] <= 1'b0;
                end else if (init_req) begin
                    q[i] <= cin.init[i];
                end else if (clr_i) begin
                    q[i] <= 1'b0;
                end else if (ctl.pre) begin
                    q[i] <= 1'b1;
                end else if (cin.load) begin
                    q[i] <= cin.d[i];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ---- core/rcp_top.sv ----
// top: APB register file, chip-wide reset pin and logic clusters
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rcp_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        chip_reset_low_pad,
    output logic             chip_reset_low_drv,
    output logic             chip_reset_low_oe_n
);

    // ********************************************************************
    // registers
    // ********************************************************************
    logic [31:0] ctrl;
    logic [31:0] data_in;
    logic [31:0] initv;
    logic [31:0] clra;
    logic [31:0] clrb;
    logic [31:0] pre;
    logic [31:0] clrsel;
    logic        load_pulse;
    logic        init_req;
    logic        pin_s1;
    logic        pin_s2;
    logic [31:0] prdata_q;
    wire  logic [rcp_pkg::NREG-1:0] q_all;
    wire  logic  rst_en;
    wire  logic  chip_reset;

    // ********************************************************************
    // apb phase tracker
    // ********************************************************************
    rcp_pkg::rcp_phase_e phase;
    rcp_pkg::rcp_phase_e next_phase;
    wire logic           setup;
    wire logic           in_access;
    wire logic           rd_setup;

    // a setup cycle arms the access phase; penable without it is ignored
    assign setup     = psel & ~penable;
    assign in_access = phase == rcp_pkg::RCP_ACCESS;
    assign rd_setup  = setup & ~pwrite;

    always_comb begin
        case (phase)
            rcp_pkg::RCP_IDLE: begin
                next_phase = setup ? rcp_pkg::RCP_ACCESS : rcp_pkg::RCP_IDLE;
            end
            rcp_pkg::RCP_ACCESS: begin
                // no wait states: one access cycle ends the transfer
                next_phase = setup ? rcp_pkg::RCP_ACCESS : rcp_pkg::RCP_IDLE;
            end
            default: begin
                next_phase = rcp_pkg::RCP_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= rcp_pkg::RCP_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    // ********************************************************************
    // apb decode
    // ********************************************************************
    wire logic access;
    wire logic wr;
    wire logic hit_ctrl;
    wire logic hit_data;
    wire logic hit_q;
    wire logic hit_init;
    wire logic hit_clra;
    wire logic hit_clrb;
    wire logic hit_pre;
    wire logic hit_csel;
    wire logic hit_sta;
    wire logic mapped;
    wire logic [31:0] wmask;

    assign access   = psel & penable & in_access;
    assign wr       = access & pwrite;
    assign hit_ctrl = paddr == rcp_pkg::OFS_CTRL;
    assign hit_data = paddr == rcp_pkg::OFS_DATA;
    assign hit_q    = paddr == rcp_pkg::OFS_Q;
    assign hit_init = paddr == rcp_pkg::OFS_INITV;
    assign hit_clra = paddr == rcp_pkg::OFS_CLRA;
    assign hit_clrb = paddr == rcp_pkg::OFS_CLRB;
    assign hit_pre  = paddr == rcp_pkg::OFS_PRE;
    assign hit_csel = paddr == rcp_pkg::OFS_CLRSEL;
    assign hit_sta  = paddr == rcp_pkg::OFS_STATUS;
    assign mapped   = hit_ctrl | hit_data | hit_q | hit_init | hit_clra
                    | hit_clrb | hit_pre | hit_csel | hit_sta;
    assign wmask    = {{8{pstrb[3]}}, {8{pstrb[2]}},
                       {8{pstrb[1]}}, {8{pstrb[0]}}};

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata  = prdata_q;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // ********************************************************************
    // register writes
    // ********************************************************************
    // only one clear A, clear B and preset bit exists per cluster
    localparam logic [31:0] CL_MASK = {{(32 - rcp_pkg::CLUSTER){1'b0}},
                                       {rcp_pkg::CLUSTER{1'b1}}};

    wire logic we_ctrl;
    wire logic we_data;
    wire logic we_init;
    wire logic we_clra;
    wire logic we_clrb;
    wire logic we_pre;
    wire logic we_csel;
    // one write enable per register, taken in the access cycle
    assign we_ctrl = wr & hit_ctrl;
    assign we_data = wr & hit_data;
    assign we_init = wr & hit_init;
    assign we_clra = wr & hit_clra;
    assign we_clrb = wr & hit_clrb;
    assign we_pre  = wr & hit_pre;
    assign we_csel = wr & hit_csel;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= rcp_pkg::CTRL_RESET;
        end else if (we_ctrl) begin
            ctrl <= merge(ctrl, pwdata, wmask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_in <= rcp_pkg::ZERO_WORD;
        end else if (we_data) begin
            data_in <= merge(data_in, pwdata, wmask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            initv <= rcp_pkg::ZERO_WORD;
        end else if (we_init) begin
            initv <= merge(initv, pwdata, wmask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clra <= rcp_pkg::ZERO_WORD;
        end else if (we_clra) begin
            clra <= merge(clra, pwdata, wmask) & CL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clrb <= rcp_pkg::ZERO_WORD;
        end else if (we_clrb) begin
            clrb <= merge(clrb, pwdata, wmask) & CL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre <= rcp_pkg::ZERO_WORD;
        end else if (we_pre) begin
            pre <= merge(pre, pwdata, wmask) & CL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clrsel <= rcp_pkg::ZERO_WORD;
        end else if (we_csel) begin
            clrsel <= merge(clrsel, pwdata, wmask);
        end
    end

    // load strobe: a write of one to the load bit of ctrl
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_pulse <= 1'b0;
        end else begin
            load_pulse <= wr & hit_ctrl & pstrb[0]
                        & pwdata[rcp_pkg::CTRL_LOAD];
        end
    end

    // power-up initialisation after presetn or a chip reset is released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_req <= 1'b1;
        end else begin
            // re-armed while chip reset holds, applied on its release
            init_req <= chip_reset;
        end
    end

    // ********************************************************************
    // chip-wide reset pin
    // ********************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
        end else begin
            pin_s1 <= chip_reset_low_pad;
            pin_s2 <= pin_s1;
        end
    end

    assign rst_en     = ctrl[rcp_pkg::CTRL_RST_EN];
    assign chip_reset = rst_en & ~pin_s2;
    // gpio mode only when the reset function is off
    assign chip_reset_low_drv  = ctrl[rcp_pkg::CTRL_GPIO_O];
    assign chip_reset_low_oe_n = ~(~rst_en & ctrl[rcp_pkg::CTRL_GPIO_D]);

    // ********************************************************************
    // read mux
    // ********************************************************************
    wire logic [31:0] status;
    wire logic [31:0] rmux;
    assign status[31:2]                 = 30'h0000_0000;
    assign status[rcp_pkg::STA_PIN]     = pin_s2;
    assign status[rcp_pkg::STA_CHIPRST] = chip_reset;
    assign rmux = hit_ctrl ? ctrl
                : hit_data ? data_in
                : hit_q    ? q_all
                : hit_init ? initv
                : hit_clra ? clra
                : hit_clrb ? clrb
                : hit_pre  ? pre
                : hit_csel ? clrsel
                : hit_sta  ? status
                : rcp_pkg::ZERO_WORD;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= rcp_pkg::ZERO_WORD;
        end else if (rd_setup) begin
            prdata_q <= rmux;
        end
    end

    // ********************************************************************
    // clusters
    // ********************************************************************
    genvar c;
    generate
        for (c = 0; c < rcp_pkg::CLUSTER; c++) begin : g_cl
            rcp_pkg::rcp_ctl_s     ctl;
            rcp_pkg::rcp_cell_in_s cin;
            localparam int unsigned LO = c * rcp_pkg::CELLS;
            // shared lines: two clears and one preset per cluster
            assign ctl.clr = {clrb[c], clra[c]};
            assign ctl.pre = pre[c];
            assign cin.d    = data_in[LO +: rcp_pkg::CELLS];
            assign cin.init = initv[LO +: rcp_pkg::CELLS];
            assign cin.csel = clrsel[LO +: rcp_pkg::CELLS];
            assign cin.load = load_pulse;
            rcp_cluster u_cl (
                .pclk       (pclk),
                .presetn    (presetn),
                .chip_reset (chip_reset),
                .init_req   (init_req),
                .ctl        (ctl),
                .cin        (cin),
                .q          (q_all[LO +: rcp_pkg::CELLS])
            );
        end
    endgenerate

endmodule
`default_nettype wire

// ---- dv/rcp_board.sv ----
// partner model: board-level source of the chip-wide reset pin
`timescale 1ns/10ps
`default_nettype none
module rcp_board (
    input  wire logic hold_low,
    input  wire logic dut_o,
    input  wire logic dut_oe_n,
    output logic      pin
);
    // board holds the pin low until it wants clears released
    // a released pin rests at its pull-up level
    assign pin = !dut_oe_n ? dut_o : !hold_low;
endmodule
`default_nettype wire

// ---- dv/rcp_top_props.sv ----
// checker: port-level properties of the clear/preset block
`timescale 1ns/10ps
`default_nettype none
module rcp_top_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        chip_reset_low_pad,
    input wire logic        chip_reset_low_drv,
    input wire logic        chip_reset_low_oe_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] sh;
    logic [2:0] low_n;
    wire acc = psel && penable;
    wire rdq = psel && !penable && !pwrite;
    wire wctl = acc && pwrite && pstrb[0] && paddr == rcp_pkg::OFS_CTRL;
    wire ctlr = paddr == rcp_pkg::OFS_CLRA || paddr == rcp_pkg::OFS_CLRB
                || paddr == rcp_pkg::OFS_PRE;
    // shadow of the ctrl option bits, taken at the write edge
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) sh <= 3'h0;
        else if (wctl) sh <= pwdata[2:0];
    // cycles of pin low with the reset function on
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) low_n <= 3'h0;
        else if (!sh[0] || chip_reset_low_pad) low_n <= 3'h0;
        else if (low_n != 3'h7) low_n <= low_n + 3'h1;
    a_pin_drive_en: assert property (
        chip_reset_low_oe_n == !(!sh[0] && sh[2])) else $error("pin enable");
    a_pin_drive_val: assert property (
        !chip_reset_low_oe_n |-> chip_reset_low_drv == sh[1])
        else $error("pin value");
    a_chip_clear_q: assert property (
        rdq && paddr == rcp_pkg::OFS_Q && low_n == 3'h7 |=> prdata == 32'h0)
        else $error("chip reset left a register set");
    a_chip_status: assert property (
        rdq && paddr == rcp_pkg::OFS_STATUS && low_n == 3'h7
        |=> prdata[1:0] == 2'h2) else $error("chip reset status");
    a_gpio_status: assert property (
        (!sh[0] && chip_reset_low_pad) [*4] ##0
        (rdq && paddr == rcp_pkg::OFS_STATUS) |=> prdata[1:0] == 2'h1)
        else $error("gpio status");
    a_ctl_width: assert property (
        rdq && ctlr |=> prdata[31:4] == 28'h0) else $error("control width");
    a_err_unmapped: assert property (
        acc && paddr > rcp_pkg::OFS_STATUS |-> pslverr) else $error("no err");
    a_err_mapped: assert property (
        acc && paddr <= rcp_pkg::OFS_STATUS && paddr[1:0] == 2'h0
        |-> !pslverr) else $error("false err");
    c_refused: cover property (acc && pslverr);
    c_chip_held: cover property (low_n == 3'h7);
    c_gpio_drive: cover property (!chip_reset_low_oe_n);
endmodule
bind rcp_top rcp_top_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pslverr(pslverr),
    .chip_reset_low_pad(chip_reset_low_pad),
    .chip_reset_low_drv(chip_reset_low_drv),
    .chip_reset_low_oe_n(chip_reset_low_oe_n));
`default_nettype wire

// ---- dv/register_clear_preset_control_tb_top.sv ----
// testbench: directed scenarios for the clear/preset control block
`timescale 1ns/10ps
`default_nettype none
module register_clear_preset_control_tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        hold = 0, pready, pslverr, pin, pin_o, pin_oe_n, e;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [3:0]  pstrb = 4'hF;
    int          n_fail = 0, n_tests = 0, n_cyc = 0;
    always #25 pclk = ~pclk;
    rcp_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chip_reset_low_pad(pin), .chip_reset_low_drv(pin_o),
        .chip_reset_low_oe_n(pin_oe_n));
    rcp_board u_board (.hold_low(hold), .dut_o(pin_o), .dut_oe_n(pin_oe_n),
        .pin(pin));
    task automatic test_done();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        n_cyc++;
        if (n_cyc == 3000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x);
    endtask
    task automatic t_reset();
        rd(rcp_pkg::OFS_Q, 32'h0);
        rd(rcp_pkg::OFS_CLRA, 32'h0);
        wr(rcp_pkg::OFS_PRE, 32'hFFFF_FFF0);
        rd(rcp_pkg::OFS_PRE, 32'h0);
        rd(rcp_pkg::OFS_STATUS, 32'h1);
        rd(12'h024, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("t_reset done");
    endtask
    task automatic t_load();
        wr(rcp_pkg::OFS_DATA, 32'hA5C3_0FF1);
        wr(rcp_pkg::OFS_CTRL, 32'h8);
        cyc(1);
        rd(rcp_pkg::OFS_Q, 32'hA5C3_0FF1);
        wr(rcp_pkg::OFS_DATA, 32'h1234_5678);
        cyc(2);
        rd(rcp_pkg::OFS_Q, 32'hA5C3_0FF1);
        $display("t_load done");
    endtask
    task automatic t_clr_pre();
        wr(rcp_pkg::OFS_PRE, 32'h1);
        rd(rcp_pkg::OFS_Q, 32'hA5C3_0FFF);
        wr(rcp_pkg::OFS_CLRSEL, 32'h0000_000F);
        wr(rcp_pkg::OFS_CLRB, 32'h1);
        rd(rcp_pkg::OFS_Q, 32'hA5C3_0FF0);
        wr(rcp_pkg::OFS_CLRA, 32'h7);
        rd(rcp_pkg::OFS_Q, 32'hA500_0000);
        wr(rcp_pkg::OFS_CLRA, 32'h0);
        wr(rcp_pkg::OFS_CLRB, 32'h0);
        wr(rcp_pkg::OFS_PRE, 32'h0);
        rd(rcp_pkg::OFS_Q, 32'hA500_00FF);
        $display("t_clr_pre done");
    endtask
    task automatic t_chip();
        wr(rcp_pkg::OFS_INITV, 32'h8E1D_2B47);
        wr(rcp_pkg::OFS_CTRL, 32'h1);
        hold <= 1'b1;
        cyc(8);
        rd(rcp_pkg::OFS_Q, 32'h0);
        rd(rcp_pkg::OFS_STATUS, 32'h2);
        hold <= 1'b0;
        cyc(6);
        rd(rcp_pkg::OFS_Q, 32'h8E1D_2B47);
        wr(rcp_pkg::OFS_CTRL, 32'h0);
        $display("t_chip done");
    endtask
    task automatic t_gpio();
        wr(rcp_pkg::OFS_CTRL, 32'h6);
        chk({30'h0, pin_oe_n, pin_o}, 32'h1);
        cyc(2);
        rd(rcp_pkg::OFS_STATUS, 32'h1);
        wr(rcp_pkg::OFS_CTRL, 32'h4);
        cyc(2);
        rd(rcp_pkg::OFS_STATUS, 32'h0);
        rd(rcp_pkg::OFS_Q, 32'h8E1D_2B47);
        wr(rcp_pkg::OFS_CTRL, 32'h0);
        chk({31'h0, pin_oe_n}, 32'h1);
        $display("t_gpio done");
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_load();
        t_clr_pre();
        t_chip();
        t_gpio();
        test_done();
    end
endmodule
`default_nettype wire
